// ===== rtl/gpio_pkg.sv
// shared constants, field layout and pin bundle type for the four-port parallel i/o block
`default_nettype none

package gpio_pkg;

  // ----------------------------------------------------------------
  // port widths
  // ----------------------------------------------------------------
  localparam int P0_W = 8;
  localparam int P1_W = 7;
  localparam int P2_W = 3;
  localparam int P3_W = 8;
  localparam int ALL_W = P0_W + P1_W + P2_W + P3_W;

  typedef struct packed {
    logic [7:0] p3;
    logic [2:0] p2;
    logic [6:0] p1;
    logic [7:0] p0;
  } port_pins_t;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_P0_LATCH = 6'h00;
  localparam logic [5:0] IDX_P1_LATCH = 6'h01;
  localparam logic [5:0] IDX_P2_LATCH = 6'h02;
  localparam logic [5:0] IDX_P3_LATCH = 6'h03;
  localparam logic [5:0] IDX_P1_DIR   = 6'h09;
  localparam logic [5:0] IDX_P3_DIR   = 6'h0A;
  localparam logic [5:0] IDX_P0_DRIVE = 6'h0B;
  localparam logic [5:0] IDX_P0_PINS  = 6'h0C;
  localparam logic [5:0] IDX_P2_PINS  = 6'h0D;
  localparam logic [5:0] IDX_CONV     = 6'h0E;
  localparam logic [5:0] IDX_PIN_CTRL = 6'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CONV_CHAN_LSB   = 0;
  localparam int CONV_AIND_BIT   = 4;
  localparam int CTRL_IRQ0_BIT   = 0;
  localparam int CTRL_IRQ1_FALL  = 1;
  localparam int CTRL_OUTPUT_DRIVE_ENABLE_BIT  = 2;
  localparam int IRQ0_PIN_BIT    = 0;
  localparam int IRQ1_PIN_BIT    = 1;
  localparam int IRQ2_PIN_BIT    = 0;
  localparam int OSC_IN_BIT      = 1;
  localparam int OSC_OUT_BIT     = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] P0_LATCH_RST = 8'hFF;
  localparam logic [7:0] P0_DRIVE_RST = 8'h00;
  localparam logic [6:0] P1_LATCH_RST = 7'h00;
  localparam logic [6:0] P1_DIR_RST   = 7'h00;
  localparam logic [2:0] P2_LATCH_RST = 3'h7;
  localparam logic [7:0] P3_LATCH_RST = 8'h00;
  localparam logic [7:0] P3_DIR_RST   = 8'h00;
  localparam logic       AIND_RST     = 1'b1;
  localparam logic [2:0] CHAN_RST     = 3'h0;
  localparam logic       IRQ0_SEL_RST = 1'b0;
  localparam logic       IRQ1_FALL_RST = 1'b0;
  localparam logic       OUTPUT_DRIVE_ENABLE_RST    = 1'b1;

endpackage : gpio_pkg

`default_nettype wire

// ===== rtl/pin_sync.sv
// two-flop synchroniser for the pin input vector
`default_nettype none

module pin_sync #(
  parameter int W = 26
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== rtl/pin_edge.sv
// registered rising and falling edge pulses for a vector of synchronised levels
`default_nettype none

module pin_edge #(
  parameter int W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev[g] <= 1'b0;
          rise[g] <= 1'b0;
          fall[g] <= 1'b0;
        end else begin
          prev[g] <= level[g];
          rise[g] <= level[g] & ~prev[g];
          fall[g] <= ~level[g] & prev[g];
        end
      end
    end
  endgenerate

endmodule : pin_edge

`default_nettype wire

// ===== rtl/four_port_parallel_io.sv
// four parallel i/o ports with avalon-mm register access
//
// Functional notes
// - four ports of 8, 7, 3, 8 bits
// - outputs latched, inputs read live
// - pins sampled in read sample phase
// - outputs change in write update phase
// - reset: port0 latch ones, drive type zero
// - port0 drive bit: 0 open-drain, 1 push-pull
// - port0 latch and pin registers read separately
// - port1 per-bit direction, reset all zero
// - port1 bit1 edge detected even when output
// - port1 bit0 io or irq0, input after reset
// - port2 latch resets to all ones
// - port2 bits1-2 oscillator in dual clock
// - port2 bit0 falling edge detected when output
// - port2 upper bits seven to three read as zero
// - stop mode floats port2 bit0
// - reset: port3 inputs, analog disable set
// - analog channel overrides port3 latch, direction
// - port3 direction one drives latch value
// - conversion: analog pins read latch, unwritable
// - port1 and port3 latch reads return pins for input bits
// - irq0 select: 0 io port, 1 interrupt
`default_nettype none

module four_port_parallel_io
  import gpio_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire port_pins_t  pin_in,
  output port_pins_t       pin_out,
  output port_pins_t       pin_oe,
  input  wire logic        stop_mode,
  input  wire logic        dual_clock_mode,
  input  wire logic        conversion_active,
  output logic      [7:0]  analog_select,
  output logic      [2:0]  irq_event
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // live pin level where a bit is input, latch where it drives
  function automatic logic [7:0] mix(input logic [7:0] drive, input logic [7:0] latch,
                                     input logic [7:0] pins);
    mix = (drive & latch) | (~drive & pins);
  endfunction

  function automatic logic [7:0] one_hot8(input logic [2:0] sel);
    one_hot8 = 8'h01 << sel;
  endfunction

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  typedef enum logic {
    phase_idle,
    write_update_phase
  } bus_phase_t;

  bus_phase_t phase;
  bus_phase_t next_phase;

  logic       read_sample_phase;
  logic       wr_en;
  logic [7:0] wr_byte;

  // the request is seen in one cycle, completed in the next;
  // the master holds address and data across both
  // every access costs two cycles; a zero-wait answer was traded away so
  // that pins are caught a full cycle before the read completes
  assign read_sample_phase = (phase == phase_idle) && read;
  assign waitrequest       = (phase != write_update_phase);
  assign wr_en   = (phase == write_update_phase) && write && byteenable[0];
  assign wr_byte = writedata[7:0];

  always_comb begin
    next_phase = phase;
    case (phase)
      phase_idle: begin
        if (read || write) begin
          next_phase = write_update_phase;
        end
      end
      write_update_phase: begin
        next_phase = phase_idle;
      end
      default: begin
        next_phase = phase_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= phase_idle;
    end else begin
      phase <= next_phase;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  port_pins_t pins;

  pin_sync #(
    .W (ALL_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pins)
  );

  logic [2:0] edge_level;
  logic [2:0] edge_rise;
  logic [2:0] edge_fall;

  // edges are taken from the pad itself, so they fire whether the
  // pin is driven from outside or by its own latch
  assign edge_level = {pins.p2[IRQ2_PIN_BIT], pins.p1[IRQ1_PIN_BIT], pins.p1[IRQ0_PIN_BIT]};

  pin_edge #(
    .W (3)
  ) u_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   (edge_level),
    .rise    (edge_rise),
    .fall    (edge_fall)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  // one output latch per port: 8, 7, 3 and 8 bits
  logic [7:0] port0_output_latch;
  logic [7:0] port0_drive_type;
  logic [6:0] port1_output_latch;
  logic [6:0] port1_direction;
  logic [2:0] port2_output_latch;
  logic [7:0] port3_output_latch;
  logic [7:0] port3_direction;
  logic       analog_input_disable;
  logic [2:0] analog_channel_select;
  logic       irq_zero_pin_select;
  logic       irq1_falling;
  logic       output_drive_enable;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_output_latch <= P0_LATCH_RST;
      port0_drive_type   <= P0_DRIVE_RST;
    end else if (wr_en && hit(address, IDX_P0_LATCH)) begin
      port0_output_latch <= wr_byte;
    end else if (wr_en && hit(address, IDX_P0_DRIVE)) begin
      port0_drive_type <= wr_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_output_latch <= P1_LATCH_RST;
      port1_direction    <= P1_DIR_RST;
    end else if (wr_en && hit(address, IDX_P1_LATCH)) begin
      port1_output_latch <= wr_byte[P1_W-1:0];
    end else if (wr_en && hit(address, IDX_P1_DIR)) begin
      port1_direction <= wr_byte[P1_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port2_output_latch <= P2_LATCH_RST;
    end else if (wr_en && hit(address, IDX_P2_LATCH)) begin
      port2_output_latch <= wr_byte[P2_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_output_latch <= P3_LATCH_RST;
      port3_direction    <= P3_DIR_RST;
    end else if (wr_en && hit(address, IDX_P3_LATCH)) begin
      port3_output_latch <= wr_byte;
    end else if (wr_en && hit(address, IDX_P3_DIR)) begin
      port3_direction <= wr_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_input_disable  <= AIND_RST;
      analog_channel_select <= CHAN_RST;
    end else if (wr_en && hit(address, IDX_CONV)) begin
      analog_input_disable  <= wr_byte[CONV_AIND_BIT];
      analog_channel_select <= wr_byte[CONV_CHAN_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_zero_pin_select <= IRQ0_SEL_RST;
      irq1_falling        <= IRQ1_FALL_RST;
      output_drive_enable <= OUTPUT_DRIVE_ENABLE_RST;
    end else if (wr_en && hit(address, IDX_PIN_CTRL)) begin
      irq_zero_pin_select <= wr_byte[CTRL_IRQ0_BIT];
      irq1_falling        <= wr_byte[CTRL_IRQ1_FALL];
      output_drive_enable <= wr_byte[CTRL_OUTPUT_DRIVE_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // port 0 drivers
  // ----------------------------------------------------------------
  // open-drain bits only ever pull low; a latch of one lets the pad
  // float so an outside signal can be read
  assign pin_out.p0 = port0_output_latch & port0_drive_type;
  assign pin_oe.p0  = port0_drive_type | ~port0_output_latch;

  // ----------------------------------------------------------------
  // port 1 drivers
  // ----------------------------------------------------------------
  logic [6:0] p1_drive;

  // bit 0 is forced to input while it serves as interrupt zero
  assign p1_drive = port1_direction
                    & ~({6'h00, irq_zero_pin_select} << IRQ0_PIN_BIT);
  assign pin_out.p1 = port1_output_latch;
  assign pin_oe.p1  = p1_drive;

  // ----------------------------------------------------------------
  // port 2 drivers
  // ----------------------------------------------------------------
  logic [2:0] p2_float;
  logic [2:0] p2_drive;

  // bits 1 and 2 belong to the low-frequency oscillator in dual-clock
  // operation; bit 0 floats in stop mode whatever the drive enable says
  assign p2_float = ({2'b00, stop_mode} << IRQ2_PIN_BIT)
                    | ({1'b0, dual_clock_mode, 1'b0} << (OSC_IN_BIT - 1))
                    | ({dual_clock_mode, 2'b00} >> (2 - OSC_OUT_BIT));
  assign p2_drive   = {3{output_drive_enable}} & ~port2_output_latch & ~p2_float;
  assign pin_out.p2 = 3'h0;
  assign pin_oe.p2  = p2_drive;

  // ----------------------------------------------------------------
  // port 3 drivers
  // ----------------------------------------------------------------
  logic [7:0] p3_analog;
  logic [7:0] p3_drive;

  assign p3_analog = analog_input_disable ? 8'h00
                                          : one_hot8(analog_channel_select);
  // analog pins are never driven, so writes cannot reach them
  assign p3_drive   = port3_direction & ~p3_analog;
  assign pin_out.p3 = port3_output_latch;
  assign pin_oe.p3  = p3_drive;
  assign analog_select = p3_analog;

  // ----------------------------------------------------------------
  // interrupt edge events
  // ----------------------------------------------------------------
  // interrupt zero needs its pin selected, the others always watch
  assign irq_event[0] = edge_fall[0] & irq_zero_pin_select;
  assign irq_event[1] = irq1_falling ? edge_fall[1] : edge_rise[1];
  assign irq_event[2] = edge_fall[2];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] p1_read;
  logic [7:0] p3_pin_view;
  logic [7:0] p3_read;
  logic [7:0] rd_byte;

  // data registers of ports without a pin register return the live
  // level of input bits, so a read-modify-write may copy pin levels
  // into those latches
  assign p1_read = mix({1'b0, p1_drive}, {1'b0, port1_output_latch},
                       {1'b0, pins.p1});
  // while converting, analog pins answer with their latch value
  assign p3_pin_view = conversion_active ? p3_analog : 8'h00;
  assign p3_read = mix(p3_drive | p3_pin_view, port3_output_latch, pins.p3);

  always_comb begin
    rd_byte = 8'h00;
    case (1'b1)
      hit(address, IDX_P0_LATCH): rd_byte = port0_output_latch;
      hit(address, IDX_P0_PINS):  rd_byte = pins.p0;
      hit(address, IDX_P0_DRIVE): rd_byte = port0_drive_type;
      hit(address, IDX_P1_LATCH): rd_byte = p1_read;
      hit(address, IDX_P1_DIR):   rd_byte = {1'b0, port1_direction};
      // upper bits of port 2 carry no state and read as zero
      hit(address, IDX_P2_LATCH): rd_byte = {5'h00, port2_output_latch};
      hit(address, IDX_P2_PINS):  rd_byte = {5'h00, pins.p2};
      hit(address, IDX_P3_LATCH): rd_byte = p3_read;
      hit(address, IDX_P3_DIR):   rd_byte = port3_direction;
      hit(address, IDX_CONV): begin
        rd_byte[CONV_CHAN_LSB +: 3] = analog_channel_select;
        rd_byte[CONV_AIND_BIT]      = analog_input_disable;
      end
      hit(address, IDX_PIN_CTRL): begin
        rd_byte[CTRL_IRQ0_BIT]  = irq_zero_pin_select;
        rd_byte[CTRL_IRQ1_FALL] = irq1_falling;
        rd_byte[CTRL_OUTPUT_DRIVE_ENABLE_BIT] = output_drive_enable;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // pins are caught once, in the first cycle of the read, and held
  // for the completing cycle; later pin changes are not seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read_sample_phase) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule : four_port_parallel_io

`default_nettype wire

// ===== dv/pad_model.sv
// pad model: resolves every pad from the block's drive and the board's own level
`default_nettype none

module pad_model
  import gpio_pkg::*;
(
  input  wire port_pins_t pin_out,
  input  wire port_pins_t pin_oe,
  input  wire port_pins_t board_level,
  output var  port_pins_t pad_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // a released pad follows the board pull or driver, never the last driven value
  assign pad_level = (pin_oe & pin_out) | (~pin_oe & board_level);

endmodule // pad_model

`default_nettype wire

// ===== dv/four_port_parallel_io_asserts.sv
// port-level assertions for the four-port parallel i/o block
`default_nettype none

module four_port_parallel_io_asserts
  import gpio_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire port_pins_t  pin_out,
  input wire port_pins_t  pin_oe,
  input wire logic        stop_mode,
  input wire logic        dual_clock_mode,
  input wire logic [7:0]  analog_select,
  input wire logic [2:0]  irq_event
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_IDLE_WAIT: assert property (!read && !write |-> waitrequest)
    else $error("waitrequest low while idle");
  AST_ONE_CYCLE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered in one cycle");
  AST_READ_HOLD: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved without a read");
  AST_HIGH_ZERO: assert property (readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_P2_UPPER: assert property (read && !waitrequest &&
      (address[7:2] == IDX_P2_LATCH || address[7:2] == IDX_P2_PINS) |-> readdata[7:3] == 5'h00)
    else $error("port2 upper read bits set");
  // port0 drive depends on registers only, so it moves only after a completed write
  AST_P0_BY_WRITE: assert property ($changed({pin_oe.p0, pin_out.p0}) |->
      $past(write) && !$past(waitrequest))
    else $error("port0 drive changed without a write");
  AST_STOP_FLOAT: assert property (stop_mode [*2] |-> !pin_oe.p2[0])
    else $error("port2 bit0 driven in stop mode");
  AST_DUAL_FLOAT: assert property (dual_clock_mode [*2] |-> pin_oe.p2[2:1] == 2'h0)
    else $error("oscillator pins driven in dual clock mode");
  AST_ANALOG: assert property ($onehot0(analog_select) && (pin_oe.p3 & analog_select) == 8'h00)
    else $error("analog pin driven or select not one-hot");
  AST_IRQ_PULSE: assert property (irq_event[2] |=> !irq_event[2])
    else $error("port2 event longer than one cycle");

endmodule // four_port_parallel_io_asserts

bind four_port_parallel_io four_port_parallel_io_asserts u_asserts (.ref_clk, .rst_n, .address,
  .read, .write, .readdata, .waitrequest, .pin_out, .pin_oe, .stop_mode, .dual_clock_mode,
  .analog_select, .irq_event);

`default_nettype wire

// ===== dv/four_port_parallel_io_bench.sv
// self-checking bench: registers, pad drive and pin events of the i/o block
`default_nettype none

module four_port_parallel_io_bench
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // signals, design and pads
  // ------------------------------------------------------------------
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic        stop_mode = 1'h0;
  logic        dual_clock_mode = 1'h0;
  logic        conversion_active = 1'h0;
  port_pins_t  board = '{p3: 8'hFF, p2: 3'h7, p1: 7'h55, p0: 8'hFF};
  logic [31:0] readdata;
  logic        waitrequest;
  port_pins_t  pad_level;
  port_pins_t  pin_out;
  port_pins_t  pin_oe;
  logic [7:0]  analog_select;
  logic [2:0]  irq_event;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          ev_cnt [3] = '{0, 0, 0};
  int          base;
  logic [31:0] d;

  always #5 ref_clk = ~ref_clk;

  four_port_parallel_io dut (.ref_clk, .rst_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .pin_in(pad_level), .pin_out, .pin_oe, .stop_mode,
    .dual_clock_mode, .conversion_active, .analog_select, .irq_event);
  pad_model pads (.pin_out, .pin_oe, .board_level(board), .pad_level);

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge; data taken and
  // request released at that same edge; a hang is caught by the cycle ceiling
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(posedge ref_clk);
    address <= addr;
    writedata <= {24'h0, wd};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'h0);
    d = readdata;
    write <= 1'h0;
    read <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    bus(1'h1, {idx, 2'h0}, wd);
  endtask

  task automatic rd(input string what, input logic [5:0] idx, input logic [7:0] exp);
    bus(1'h0, {idx, 2'h0}, 8'h00);
    chk(what, {24'h0, exp}, d);
  endtask

  // pads pass a two-flop synchroniser, so four edges cover it with margin
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    for (int k = 0; k < 3; k++) begin
      if (irq_event[k] === 1'h1) ev_cnt[k] <= ev_cnt[k] + 1;
    end
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
    chk("oe", 32'h0, 32'(pin_oe));
    chk("p1 p3 out", 32'h0, 32'({pin_out.p3, pin_out.p1}));
    rd("p0 latch", IDX_P0_LATCH, 8'hFF);
    rd("p0 drive", IDX_P0_DRIVE, 8'h00);
    rd("p1 dir", IDX_P1_DIR, 8'h00);
    rd("p2 latch", IDX_P2_LATCH, 8'h07);
    rd("p3 dir", IDX_P3_DIR, 8'h00);
    rd("conv", IDX_CONV, 8'h10);
    $display("test reset done");
    wr(IDX_P0_LATCH, 8'h5A);
    wr(IDX_P0_DRIVE, 8'h0F);
    board.p0 <= 8'h33;
    settle();
    chk("p0 oe", 32'hAF, 32'(pin_oe.p0));
    chk("p0 out", 32'h0A, 32'(pin_out.p0 & pin_oe.p0));
    rd("p0 pins", IDX_P0_PINS, 8'h1A);
    rd("p0 latch", IDX_P0_LATCH, 8'h5A);
    wr(IDX_P0_LATCH, 8'hFF);
    wr(IDX_P0_DRIVE, 8'h00);
    settle();
    rd("p0 released", IDX_P0_PINS, 8'h33);
    bus(1'h1, 8'h01, 8'h00);
    byteenable <= 4'h0;
    wr(IDX_P0_LATCH, 8'h00);
    byteenable <= 4'hF;
    bus(1'h0, 8'h14, 8'h00);
    chk("unmapped", 32'h0, d);
    rd("p0 kept", IDX_P0_LATCH, 8'hFF);
    $display("test port0 done");
    wr(IDX_P1_LATCH, 8'h7F);
    wr(IDX_P1_DIR, 8'h0F);
    settle();
    chk("p1 oe", 32'h0F, 32'(pin_oe.p1));
    rd("p1 mixed", IDX_P1_LATCH, 8'h5F);
    @(posedge ref_clk) board.p1 <= 7'h2B;
    settle();
    rd("p1 live", IDX_P1_LATCH, 8'h2F);
    base = ev_cnt[1];
    wr(IDX_P1_LATCH, 8'h7D);
    wr(IDX_P1_LATCH, 8'h7F);
    settle();
    chk("irq1", 32'(base + 1), 32'(ev_cnt[1]));
    for (int s = 0; s < 2; s++) begin
      wr(IDX_PIN_CTRL, 8'(4 + s));
      base = ev_cnt[0];
      @(posedge ref_clk) board.p1 <= 7'h2A;
      settle();
      @(posedge ref_clk) board.p1 <= 7'h2B;
      settle();
      chk("irq0", 32'(base + s), 32'(ev_cnt[0]));
      chk("p1 oe sel", 32'(15 - s), 32'(pin_oe.p1));
    end
    wr(IDX_PIN_CTRL, 8'h06);
    rd("pin ctrl", IDX_PIN_CTRL, 8'h06);
    base = ev_cnt[1];
    wr(IDX_P1_LATCH, 8'h7D);
    settle();
    chk("irq1 fall", 32'(base + 1), 32'(ev_cnt[1]));
    $display("test port1 done");
    base = ev_cnt[2];
    wr(IDX_P2_LATCH, 8'hFE);
    settle();
    chk("p2 oe", 32'h1, 32'(pin_oe.p2));
    chk("irq2", 32'(base + 1), 32'(ev_cnt[2]));
    rd("p2 pins", IDX_P2_PINS, 8'h06);
    @(posedge ref_clk) stop_mode <= 1'h1;
    settle();
    chk("p2 oe stop", 32'h0, 32'(pin_oe.p2));
    @(posedge ref_clk) stop_mode <= 1'h0;
    wr(IDX_P2_LATCH, 8'h00);
    dual_clock_mode <= 1'h1;
    settle();
    chk("p2 oe dual", 32'h1, 32'(pin_oe.p2));
    @(posedge ref_clk) dual_clock_mode <= 1'h0;
    settle();
    chk("p2 oe single", 32'h7, 32'(pin_oe.p2));
    wr(IDX_PIN_CTRL, 8'h02);
    @(negedge ref_clk);
    chk("p2 oe off", 32'h0, 32'(pin_oe.p2));
    $display("test port2 done");
    wr(IDX_P3_DIR, 8'hF8);
    settle();
    chk("p3 latch", 32'h0, 32'(pin_out.p3 & pin_oe.p3));
    wr(IDX_CONV, 8'h03);
    wr(IDX_P3_LATCH, 8'hA5);
    settle();
    chk("analog", 32'h08, 32'(analog_select));
    chk("p3 oe", 32'hF0, 32'(pin_oe.p3));
    chk("p3 out", 32'hA0, 32'(pin_out.p3 & pin_oe.p3));
    @(posedge ref_clk) conversion_active <= 1'h1;
    settle();
    rd("p3 conv", IDX_P3_LATCH, 8'hA7);
    @(posedge ref_clk) conversion_active <= 1'h0;
    settle();
    rd("p3 idle", IDX_P3_LATCH, 8'hAF);
    $display("test port3 done");
    finish_test();
  end

endmodule // four_port_parallel_io_bench

`default_nettype wire
